// File: fpe_pkg.sv
// Constants, register map and mode codes of the flash program/erase control.
// Assumes a CPU that reaches the registers over a plain byte-wide port.
//
// Summary of operation
// - Four modes selected by control one bits.
// - Latch address and 128 bytes, aligned start.
// - Program pulse lasts while program enable set.
// - Dummy FF write arms longword verify read.
// - Erase lasts while erase enable set.
// - Block all interrupts during program, erase, boot.
// - Pin reset or standby stops work, clears control one and low block select.
// - Write enable clear blocks program and erase.
// - Both block selects zero protect every block.
// - Bad read, exception or sleep during program or erase sets error.
// - Error keeps registers, aborts, blocks re-entry.
// - Verify modes still allowed under error.
// - Only power-on reset clears error.
// - Standby halts flash; software waits 20 us.
// - Overlay select blocks program and erase.
package fpe_pkg;

    // Register byte addresses.
    localparam logic [15:0] ADDR_RAM_OVERLAY_CONTROL = 16'hfedb;
    localparam logic [15:0] ADDR_FLASH_CONTROL_ONE = 16'hffa8;
    localparam logic [15:0] ADDR_FLASH_CONTROL_TWO = 16'hffa9;
    localparam logic [15:0] ADDR_ERASE_BLOCK_SELECT_LOW = 16'hffaa;
    localparam logic [15:0] ADDR_ERASE_BLOCK_SELECT_HIGH = 16'hffab;
    localparam logic [15:0] ADDR_FLASH_POWER_CONTROL = 16'hffac;

    // Field positions in flash_control_one.
    localparam int FC1_PROGRAM_ENABLE_BIT = 0;
    localparam int FC1_ERASE_ENABLE_BIT = 1;
    localparam int FC1_PROGRAM_VERIFY_BIT = 2;
    localparam int FC1_ERASE_VERIFY_BIT = 3;
    localparam int FC1_SOFTWARE_WRITE_ENABLE = 6;
    // Writable bits of flash_control_one; the rest read as zero.
    localparam logic [7:0] FC1_WRITE_MASK = 8'h4f;

    // Error flag position in flash_control_two.
    localparam int FC2_FLASH_ERROR_FLAG = 7;

    // Overlay select position in ram_overlay_control.
    localparam int ROC_OVERLAY_SELECT_BIT = 3;
    localparam logic [7:0] ROC_WRITE_MASK = 8'h0f;

    // Power control writable bits.
    localparam logic [7:0] FPC_WRITE_MASK = 8'h80;

    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Page latch geometry.
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_IDX_W = 7;
    localparam int FLASH_ADDR_W = 24;
    localparam logic [7:0] PAGE_START_LOW = 8'h00;
    localparam logic [7:0] PAGE_START_HIGH = 8'h80;

    // Verify dummy write pattern.
    localparam logic [7:0] VERIFY_DUMMY_DATA = 8'hff;
    localparam logic [1:0] VERIFY_ADDR_LOW = 2'h0;

    // Operating mode of the array.
    typedef enum logic [2:0] {
        FPE_MODE_IDLE = 3'b000,
        FPE_MODE_PROGRAM = 3'b001,
        FPE_MODE_PROG_VERIFY = 3'b010,
        FPE_MODE_ERASE = 3'b011,
        FPE_MODE_ERASE_VERIFY = 3'b100
    } fpe_mode_e;

endpackage

// File: fpe_page_latch.sv
// Page latch: holds one program page of bytes and its start address.
// Assumes the caller gates writes so that none arrive while programming.
`timescale 1ns/1ps
module fpe_page_latch
    import fpe_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_clear,
    input wire logic i_wr,
    input wire logic [FLASH_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [PAGE_IDX_W-1:0] i_rd_idx,
    output logic o_full,
    output logic [FLASH_ADDR_W-1:0] o_start,
    output logic [7:0] o_rd_data
);
    logic [7:0] mem_r [PAGE_BYTES];
    logic [PAGE_IDX_W:0] count_r, count_nxt;
    logic [FLASH_ADDR_W-1:0] start_r, start_nxt;
    logic take;
    logic [FLASH_ADDR_W-1:0] expect_addr;

    // A first byte must sit on an aligned start; later bytes must follow.
    always_comb begin
        expect_addr = start_r + FLASH_ADDR_W'(count_r);
        take = 1'b0;
        if (i_wr && !count_r[PAGE_IDX_W]) begin
            if (count_r == '0) begin
                take = (i_addr[7:0] == PAGE_START_LOW) ||
                       (i_addr[7:0] == PAGE_START_HIGH);
            end else begin
                take = (i_addr == expect_addr);
            end
        end
        count_nxt = count_r;
        start_nxt = start_r;
        if (i_clear) begin
            count_nxt = '0;
        end else if (take) begin
            count_nxt = count_r + 1'b1;
            if (count_r == '0) begin
                start_nxt = i_addr;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_r <= '0;
            start_r <= '0;
        end else begin
            count_r <= count_nxt;
            start_r <= start_nxt;
        end
    end

    // One storage byte per page entry, written at its own index.
    genvar gi;
    generate
        for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_byte
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    mem_r[gi] <= RST_BYTE;
                end else if (take &&
                             count_r[PAGE_IDX_W-1:0] == PAGE_IDX_W'(gi)) begin
                    mem_r[gi] <= i_wdata;
                end
            end
        end
    endgenerate

    assign o_full = count_r[PAGE_IDX_W];
    assign o_start = start_r;
    assign o_rd_data = mem_r[i_rd_idx];
endmodule

// File: fpe_flash_ctrl.sv
// Top of the flash program/erase control: registers, mode decode,
// protection and error detection, page latch and verify arming.
// Assumes the CPU bus, interrupt controller and array sit outside.
`timescale 1ns/1ps
module fpe_flash_ctrl
    import fpe_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic I_PIN_RESET,
    input wire logic I_STANDBY,
    input wire logic [15:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic I_FLASH_WR,
    input wire logic [fpe_pkg::FLASH_ADDR_W-1:0] I_FLASH_ADDR,
    input wire logic [7:0] I_FLASH_WDATA,
    input wire logic I_FLASH_READ,
    input wire logic I_EXCEPTION,
    input wire logic I_SLEEP_EXEC,
    input wire logic I_BOOT_RUNNING,
    input wire logic [fpe_pkg::PAGE_IDX_W-1:0] I_PAGE_IDX,
    output logic [7:0] O_PAGE_DATA,
    output logic [fpe_pkg::FLASH_ADDR_W-1:0] O_PAGE_START,
    output logic O_PAGE_FULL,
    output logic [2:0] O_MODE,
    output logic [15:0] O_ERASE_BLOCKS,
    output logic O_VERIFY_ARMED,
    output logic [fpe_pkg::FLASH_ADDR_W-1:0] O_VERIFY_ADDR,
    output logic O_INT_BLOCK,
    output logic O_FLASH_STANDBY,
    output logic O_ERROR
);
    import fpe_pkg::*;

    logic [7:0] fc1_r, fc1_nxt;
    logic [7:0] ebl_r, ebl_nxt;
    logic [7:0] ebh_r, ebh_nxt;
    logic [7:0] roc_r, roc_nxt;
    logic [7:0] fpc_r, fpc_nxt;
    logic err_r, err_nxt;
    fpe_mode_e mode_r, mode_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [15:0] blocks_r, blocks_nxt;
    logic int_block_r, int_block_nxt;
    logic stby_r, stby_nxt;
    logic varm_r, varm_nxt;
    logic [FLASH_ADDR_W-1:0] vaddr_r, vaddr_nxt;
    logic [7:0] page_data_r;
    logic [FLASH_ADDR_W-1:0] page_start_r;
    logic page_full_r;
    logic init_regs, pe_allowed, busy_now, err_event, page_wr, page_clear;
    logic lat_full;
    logic [FLASH_ADDR_W-1:0] lat_start;
    logic [7:0] lat_data;
    logic [15:0] block_sel;

    // Pin reset and standby wipe control state but never the error flag.
    assign init_regs = I_PIN_RESET || I_STANDBY;
    assign busy_now = (mode_r == FPE_MODE_PROGRAM) ||
                      (mode_r == FPE_MODE_ERASE);
    assign err_event = busy_now &&
                       (I_FLASH_READ || I_EXCEPTION || I_SLEEP_EXEC);
    assign block_sel = {ebh_r, ebl_r};

    // Register next values; writes only reach writable fields.
    always_comb begin
        fc1_nxt = fc1_r;
        ebl_nxt = ebl_r;
        ebh_nxt = ebh_r;
        roc_nxt = roc_r;
        fpc_nxt = fpc_r;
        if (I_WR) begin
            unique case (I_ADDR)
                ADDR_FLASH_CONTROL_ONE: fc1_nxt = I_WDATA & FC1_WRITE_MASK;
                ADDR_ERASE_BLOCK_SELECT_LOW: ebl_nxt = I_WDATA;
                ADDR_ERASE_BLOCK_SELECT_HIGH: ebh_nxt = I_WDATA;
                ADDR_RAM_OVERLAY_CONTROL: roc_nxt = I_WDATA & ROC_WRITE_MASK;
                ADDR_FLASH_POWER_CONTROL: fpc_nxt = I_WDATA & FPC_WRITE_MASK;
                default: ;
            endcase
        end
        if (init_regs) begin
            fc1_nxt = RST_BYTE;
            ebl_nxt = RST_BYTE;
        end
        // The error flag is set by hardware only and cleared by power-on.
        err_nxt = err_r || err_event;
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            fc1_r <= RST_BYTE;
            ebl_r <= RST_BYTE;
            ebh_r <= RST_BYTE;
            roc_r <= RST_BYTE;
            fpc_r <= RST_BYTE;
            err_r <= 1'b0;
        end else begin
            fc1_r <= fc1_nxt;
            ebl_r <= ebl_nxt;
            ebh_r <= ebh_nxt;
            roc_r <= roc_nxt;
            fpc_r <= fpc_nxt;
            err_r <= err_nxt;
        end
    end

    // Mode decode from the next register values, so an error or a cleared
    // enable drops the array out of program or erase on the next edge.
    always_comb begin
        pe_allowed = fc1_nxt[FC1_SOFTWARE_WRITE_ENABLE] &&
                     !err_nxt &&
                     !roc_nxt[ROC_OVERLAY_SELECT_BIT] &&
                     !I_STANDBY;
        mode_nxt = FPE_MODE_IDLE;
        blocks_nxt = '0;
        if (pe_allowed && fc1_nxt[FC1_PROGRAM_ENABLE_BIT]) begin
            mode_nxt = FPE_MODE_PROGRAM;
        end else if (pe_allowed && fc1_nxt[FC1_ERASE_ENABLE_BIT] &&
                     ({ebh_nxt, ebl_nxt} != '0)) begin
            mode_nxt = FPE_MODE_ERASE;
            blocks_nxt = {ebh_nxt, ebl_nxt};
        end else if (fc1_nxt[FC1_SOFTWARE_WRITE_ENABLE] && !I_STANDBY &&
                     fc1_nxt[FC1_PROGRAM_VERIFY_BIT]) begin
            mode_nxt = FPE_MODE_PROG_VERIFY;
        end else if (fc1_nxt[FC1_SOFTWARE_WRITE_ENABLE] && !I_STANDBY &&
                     fc1_nxt[FC1_ERASE_VERIFY_BIT]) begin
            mode_nxt = FPE_MODE_ERASE_VERIFY;
        end
        int_block_nxt = (mode_nxt == FPE_MODE_PROGRAM) ||
                        (mode_nxt == FPE_MODE_ERASE) ||
                        I_BOOT_RUNNING;
        stby_nxt = I_STANDBY;
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            mode_r <= FPE_MODE_IDLE;
            blocks_r <= '0;
            int_block_r <= 1'b0;
            stby_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            blocks_r <= blocks_nxt;
            int_block_r <= int_block_nxt;
            stby_r <= stby_nxt;
        end
    end

    // A byte write of all ones to a longword address in a verify mode arms
    // the verify read; leaving verify disarms it.
    always_comb begin
        varm_nxt = varm_r;
        vaddr_nxt = vaddr_r;
        if ((mode_r != FPE_MODE_PROG_VERIFY) &&
            (mode_r != FPE_MODE_ERASE_VERIFY)) begin
            varm_nxt = 1'b0;
        end else if (I_FLASH_WR && (I_FLASH_WDATA == VERIFY_DUMMY_DATA) &&
                     (I_FLASH_ADDR[1:0] == VERIFY_ADDR_LOW)) begin
            varm_nxt = 1'b1;
            vaddr_nxt = I_FLASH_ADDR;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            varm_r <= 1'b0;
            vaddr_r <= '0;
        end else begin
            varm_r <= varm_nxt;
            vaddr_r <= vaddr_nxt;
        end
    end

    // Page bytes are taken only while write enable is set and no mode runs;
    // the page empties when a programming pulse ends or on reset/standby.
    assign page_wr = I_FLASH_WR && (mode_r == FPE_MODE_IDLE) &&
                     fc1_r[FC1_SOFTWARE_WRITE_ENABLE];
    assign page_clear = init_regs || ((mode_r == FPE_MODE_PROGRAM) &&
                        (mode_nxt != FPE_MODE_PROGRAM));

    fpe_page_latch u_page (
        .i_clk(I_REF_CLK),
        .i_reset(I_RESET),
        .i_clear(page_clear),
        .i_wr(page_wr),
        .i_addr(I_FLASH_ADDR),
        .i_wdata(I_FLASH_WDATA),
        .i_rd_idx(I_PAGE_IDX),
        .o_full(lat_full),
        .o_start(lat_start),
        .o_rd_data(lat_data)
    );

    // Read data mux; unmapped addresses and idle cycles return zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (I_RD) begin
            unique case (I_ADDR)
                ADDR_FLASH_CONTROL_ONE: rdata_nxt = fc1_r;
                ADDR_FLASH_CONTROL_TWO:
                    rdata_nxt = {err_r, 7'h00};
                ADDR_ERASE_BLOCK_SELECT_LOW: rdata_nxt = ebl_r;
                ADDR_ERASE_BLOCK_SELECT_HIGH: rdata_nxt = ebh_r;
                ADDR_RAM_OVERLAY_CONTROL: rdata_nxt = roc_r;
                ADDR_FLASH_POWER_CONTROL: rdata_nxt = fpc_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            rdata_r <= 8'h00;
            page_data_r <= 8'h00;
            page_start_r <= '0;
            page_full_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            page_data_r <= lat_data;
            page_start_r <= lat_start;
            page_full_r <= lat_full;
        end
    end

    assign O_RDATA = rdata_r;
    assign O_PAGE_DATA = page_data_r;
    assign O_PAGE_START = page_start_r;
    assign O_PAGE_FULL = page_full_r;
    assign O_MODE = mode_r;
    assign O_ERASE_BLOCKS = blocks_r;
    assign O_VERIFY_ARMED = varm_r;
    assign O_VERIFY_ADDR = vaddr_r;
    assign O_INT_BLOCK = int_block_r;
    assign O_FLASH_STANDBY = stby_r;
    assign O_ERROR = err_r;

    // Checks that guard the mode and protection logic.
    sequence s_busy_fault;
        busy_now && (I_FLASH_READ || I_EXCEPTION || I_SLEEP_EXEC);
    endsequence
    sequence s_aborted;
        err_r && !busy_now;
    endsequence

    property p_error_aborts;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        s_busy_fault |=> s_aborted;
    endproperty
    a_error_aborts: assert property (p_error_aborts)
        else $error("Fault during program or erase did not abort.");

    property p_error_sticky;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        err_r |=> err_r;
    endproperty
    a_error_sticky: assert property (p_error_sticky)
        else $error("Error flag cleared without power-on reset.");

    property p_no_reentry;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        err_r |-> !busy_now;
    endproperty
    a_no_reentry: assert property (p_no_reentry)
        else $error("Program or erase entered under error protection.");

    property p_swe_protect;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        busy_now |-> $past(fc1_nxt[FC1_SOFTWARE_WRITE_ENABLE]);
    endproperty
    a_swe_protect: assert property (p_swe_protect)
        else $error("Program or erase without software write enable.");

    property p_overlay_protect;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        roc_r[ROC_OVERLAY_SELECT_BIT] |-> !busy_now;
    endproperty
    a_overlay_protect: assert property (p_overlay_protect)
        else $error("Program or erase while overlay selected.");

    property p_erase_blocks;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        (mode_r == FPE_MODE_ERASE) |-> (blocks_r != '0) &&
            (blocks_r == block_sel);
    endproperty
    a_erase_blocks: assert property (p_erase_blocks)
        else $error("Erase with no or wrong block selection.");

    property p_int_block;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        busy_now |-> int_block_r;
    endproperty
    a_int_block: assert property (p_int_block)
        else $error("Interrupts not blocked during program or erase.");

    property p_standby_init;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        I_STANDBY |=> (fc1_r == RST_BYTE) && (ebl_r == RST_BYTE) &&
            !busy_now && stby_r;
    endproperty
    a_standby_init: assert property (p_standby_init)
        else $error("Standby did not stop and initialise the flash.");

    property p_pulse_follows_bit;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        (mode_r == FPE_MODE_PROGRAM) |-> fc1_r[FC1_PROGRAM_ENABLE_BIT];
    endproperty
    a_pulse_follows_bit: assert property (p_pulse_follows_bit)
        else $error("Program pulse without program enable bit.");

    property p_read_error;
        @(posedge I_REF_CLK) disable iff (I_RESET)
        (I_RD && I_ADDR == ADDR_FLASH_CONTROL_TWO) |=>
            (O_RDATA[FC2_FLASH_ERROR_FLAG] == $past(err_r));
    endproperty
    a_read_error: assert property (p_read_error)
        else $error("Error flag not visible on read.");
endmodule

// File: fpe_cpu_model.sv
// CPU model: runs the program/erase control software against the block.
// Assumes one clock shared with the block; every drive follows a rising edge.
`timescale 1ns/1ps
module fpe_cpu_model (
    input wire logic i_clk,
    output logic [15:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [7:0] i_rdata,
    output logic o_flash_wr,
    output logic [fpe_pkg::FLASH_ADDR_W-1:0] o_flash_addr,
    output logic [7:0] o_flash_wdata,
    output logic o_flash_read,
    output logic o_exception,
    output logic o_sleep_exec
);
    import fpe_pkg::*;

    // Retry ceilings of the software loops; the runs here stay far below.
    localparam int MAX_PROG_LOOPS = 1000;
    localparam int MAX_ERASE_LOOPS = 100;
    // Watchdog periods software would set; the watchdog sits elsewhere.
    localparam real WDT_PROG_MS = 6.6;
    localparam real WDT_ERASE_MS = 19.8;

    // Idle values at time zero.
    initial begin
        {o_addr, o_wdata, o_wr, o_rd, o_flash_wr, o_flash_addr} = '0;
        {o_flash_wdata, o_flash_read, o_exception, o_sleep_exec} = '0;
    end

    // One register write; released lines show inverted values afterwards.
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    // One register read; the data stand in the cycle after the strobe.
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask

    // One byte write into flash space.
    task automatic flash_wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_flash_addr <= a;
        o_flash_wdata <= d;
        o_flash_wr <= 1'b1;
        @(posedge i_clk);
        o_flash_wr <= 1'b0;
        o_flash_addr <= ~a;
        o_flash_wdata <= ~d;
    endtask

    // Full page into an erased area; bytes past n are padded with ff.
    task automatic page_load(input logic [23:0] start, input int n);
        for (int i = 0; i < PAGE_BYTES; i++) begin
            flash_wr(start + 24'(i), (i < n) ? 8'(i) ^ 8'h5a : 8'hff);
        end
    endtask

    // Dummy write that arms a verify read at a longword address.
    task automatic dummy_verify(input logic [23:0] a);
        flash_wr({a[23:2], 2'b00}, 8'hff);
    endtask

    // Selects exactly one block across the two select registers.
    task automatic erase_select(input int blk);
        reg_wr(ADDR_ERASE_BLOCK_SELECT_LOW, 8'(16'h1 << blk));
        reg_wr(ADDR_ERASE_BLOCK_SELECT_HIGH, 8'((16'h1 << blk) >> 8));
    endtask

    // One-cycle fault event: 0 flash read, 1 exception, 2 sleep.
    task automatic fault(input int k);
        @(posedge i_clk);
        o_flash_read <= (k == 0);
        o_exception <= (k == 1);
        o_sleep_exec <= (k == 2);
        @(posedge i_clk);
        {o_flash_read, o_exception, o_sleep_exec} <= 3'b000;
    endtask
endmodule

// File: tb_flash_program_erase_control.sv
// Testbench of the flash program/erase control, driven by the CPU model.
// Assumes the block's registered outputs settle one step after each edge.
`timescale 1ns/1ps
module tb_flash_program_erase_control;
    import fpe_pkg::*;
    logic ref_clk, reset, pin_reset, standby, boot_running;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, page_data, d, flash_wdata;
    logic wr, rd, flash_wr, flash_read, exc, sleep_exec;
    logic [23:0] flash_addr, page_start, verify_addr;
    logic [PAGE_IDX_W-1:0] page_idx;
    logic page_full, verify_armed, int_block, flash_standby, error;
    logic [2:0] mode;
    logic [15:0] erase_blocks;
    int n_fail = 0, n_checks = 0;

    fpe_flash_ctrl i_dut (.I_REF_CLK(ref_clk), .I_RESET(reset),
        .I_PIN_RESET(pin_reset), .I_STANDBY(standby), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_FLASH_WR(flash_wr), .I_FLASH_ADDR(flash_addr),
        .I_FLASH_WDATA(flash_wdata), .I_FLASH_READ(flash_read),
        .I_EXCEPTION(exc), .I_SLEEP_EXEC(sleep_exec),
        .I_BOOT_RUNNING(boot_running), .I_PAGE_IDX(page_idx),
        .O_PAGE_DATA(page_data), .O_PAGE_START(page_start),
        .O_PAGE_FULL(page_full), .O_MODE(mode), .O_ERASE_BLOCKS(erase_blocks),
        .O_VERIFY_ARMED(verify_armed), .O_VERIFY_ADDR(verify_addr),
        .O_INT_BLOCK(int_block), .O_FLASH_STANDBY(flash_standby),
        .O_ERROR(error));

    fpe_cpu_model i_cpu (.i_clk(ref_clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .i_rdata(rdata), .o_flash_wr(flash_wr),
        .o_flash_addr(flash_addr), .o_flash_wdata(flash_wdata),
        .o_flash_read(flash_read), .o_exception(exc),
        .o_sleep_exec(sleep_exec));

    // 200 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Cuts a hung run short.
    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        i_cpu.reg_rd(a, d);
        check("register read", 24'(exp), 24'(d));
    endtask

    // Waits n edges and lets their updates land.
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Power-on reset held for two cycles.
    task automatic por;
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
    endtask

    // Reset values, access kinds and an unmapped address.
    task automatic t_regs;
        logic [15:0] map [6] = '{ADDR_RAM_OVERLAY_CONTROL,
            ADDR_FLASH_CONTROL_ONE, ADDR_FLASH_CONTROL_TWO,
            ADDR_ERASE_BLOCK_SELECT_LOW, ADDR_ERASE_BLOCK_SELECT_HIGH,
            ADDR_FLASH_POWER_CONTROL};
        foreach (map[i]) rd_chk(map[i], 8'h00);
        rd_chk(16'hffad, 8'h00);
        i_cpu.reg_wr(ADDR_RAM_OVERLAY_CONTROL, 8'hff);
        rd_chk(ADDR_RAM_OVERLAY_CONTROL, 8'h0f);
        i_cpu.reg_wr(ADDR_FLASH_POWER_CONTROL, 8'hff);
        rd_chk(ADDR_FLASH_POWER_CONTROL, 8'h80);
        i_cpu.reg_wr(ADDR_ERASE_BLOCK_SELECT_HIGH, 8'ha5);
        rd_chk(ADDR_ERASE_BLOCK_SELECT_HIGH, 8'ha5);
        i_cpu.reg_wr(ADDR_FLASH_CONTROL_TWO, 8'hff);
        rd_chk(ADDR_FLASH_CONTROL_TWO, 8'h00);
        por();
    endtask

    // Writes control one and checks the mode at the edge that takes it.
    task automatic set_mode(input logic [7:0] v, input fpe_mode_e m);
        i_cpu.reg_wr(ADDR_FLASH_CONTROL_ONE, v);
        #1 check("mode", 24'(m), 24'(mode));
    endtask

    // Software, emulation and block protection.
    task automatic t_protect;
        set_mode(8'h40, FPE_MODE_IDLE);
        i_cpu.page_load(24'h000100, 128);
        set_mode(8'h01, FPE_MODE_IDLE);
        i_cpu.reg_wr(ADDR_RAM_OVERLAY_CONTROL, 8'h08);
        set_mode(8'h41, FPE_MODE_IDLE);
        i_cpu.reg_wr(ADDR_RAM_OVERLAY_CONTROL, 8'h00);
        set_mode(8'h41, FPE_MODE_PROGRAM);
        set_mode(8'h40, FPE_MODE_IDLE);
        set_mode(8'h42, FPE_MODE_IDLE);
        por();
    endtask

    // Page latch, program pulse and program-verify.
    task automatic t_program;
        set_mode(8'h40, FPE_MODE_IDLE);
        i_cpu.flash_wr(24'h000401, 8'h11);
        i_cpu.page_load(24'h000480, 64);
        step(2);
        check("page full", 24'h1, 24'(page_full));
        check("page start", 24'h000480, page_start);
        page_idx <= 7'd5;
        step(2);
        check("page byte", 24'h00005f, 24'(page_data));
        page_idx <= 7'd100;
        step(2);
        check("page pad", 24'h0000ff, 24'(page_data));
        set_mode(8'h41, FPE_MODE_PROGRAM);
        check("int block", 24'h1, 24'(int_block));
        step(20);
        check("mode held", 24'(FPE_MODE_PROGRAM), 24'(mode));
        set_mode(8'h40, FPE_MODE_IDLE);
        check("int block", 24'h0, 24'(int_block));
        set_mode(8'h44, FPE_MODE_PROG_VERIFY);
        i_cpu.dummy_verify(24'h000486);
        step(1);
        check("armed", 24'h1, 24'(verify_armed));
        check("verify addr", 24'h000484, verify_addr);
        set_mode(8'h40, FPE_MODE_IDLE);
        step(1);
        check("disarmed", 24'h0, 24'(verify_armed));
    endtask

    // Erase pulse of one block and erase-verify.
    task automatic t_erase;
        i_cpu.erase_select(9);
        set_mode(8'h42, FPE_MODE_ERASE);
        check("blocks", 24'h000200, 24'(erase_blocks));
        check("int block", 24'h1, 24'(int_block));
        step(30);
        check("mode held", 24'(FPE_MODE_ERASE), 24'(mode));
        set_mode(8'h40, FPE_MODE_IDLE);
        check("blocks", 24'h0, 24'(erase_blocks));
        set_mode(8'h48, FPE_MODE_ERASE_VERIFY);
        i_cpu.dummy_verify(24'h000203);
        #1 check("armed", 24'h1, 24'(verify_armed));
        check("verify addr", 24'h000200, verify_addr);
    endtask

    // Every fault kind during erase, then pin and power-on reset.
    task automatic t_error;
        for (int k = 0; k < 3; k++) begin
            por();
            i_cpu.erase_select(0);
            set_mode(8'h42, FPE_MODE_ERASE);
            i_cpu.fault(k);
            #1 check("error", 24'h1, 24'(error));
            check("aborted", 24'(FPE_MODE_IDLE), 24'(mode));
            rd_chk(ADDR_FLASH_CONTROL_ONE, 8'h42);
            rd_chk(ADDR_FLASH_CONTROL_TWO, 8'h80);
            i_cpu.reg_wr(ADDR_FLASH_CONTROL_TWO, 8'h00);
            rd_chk(ADDR_FLASH_CONTROL_TWO, 8'h80);
            set_mode(8'h40, FPE_MODE_IDLE);
            set_mode(8'h42, FPE_MODE_IDLE);
            set_mode(8'h48, FPE_MODE_ERASE_VERIFY);
            set_mode(8'h44, FPE_MODE_PROG_VERIFY);
            @(posedge ref_clk);
            pin_reset <= 1'b1;
            @(posedge ref_clk);
            pin_reset <= 1'b0;
            rd_chk(ADDR_FLASH_CONTROL_ONE, 8'h00);
            rd_chk(ADDR_ERASE_BLOCK_SELECT_LOW, 8'h00);
            check("error kept", 24'h1, 24'(error));
        end
        por();
        step(1);
        check("error cleared", 24'h0, 24'(error));
    endtask

    // Standby in mid-programming, then boot-time interrupt blocking.
    task automatic t_standby;
        set_mode(8'h40, FPE_MODE_IDLE);
        i_cpu.page_load(24'h000000, 128);
        set_mode(8'h41, FPE_MODE_PROGRAM);
        @(posedge ref_clk);
        standby <= 1'b1;
        step(2);
        check("standby mode", 24'(FPE_MODE_IDLE), 24'(mode));
        check("flash standby", 24'h1, 24'(flash_standby));
        @(posedge ref_clk);
        standby <= 1'b0;
        step(2);
        check("flash awake", 24'h0, 24'(flash_standby));
        rd_chk(ADDR_FLASH_CONTROL_ONE, 8'h00);
        @(posedge ref_clk);
        boot_running <= 1'b1;
        step(2);
        check("boot block", 24'h1, 24'(int_block));
        boot_running <= 1'b0;
        step(2);
        check("boot unblock", 24'h0, 24'(int_block));
    endtask

    // Main sequence.
    initial begin
        {reset, pin_reset, standby, boot_running} = 4'b1000;
        page_idx = '0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_protect();
        t_program();
        t_erase();
        t_error();
        t_standby();
        summarize();
    end
endmodule
